// ### hdl/hbg_gate_logic.sv
// Purpose: full-bridge gate command logic with protection and APB registers
// Assumes: condition inputs are filtered and synchronous to i_clk
// Notes:   gate order high_a, low_a, high_b, low_b in all vectors
// How it works
// - Pulse high picks diagonal by direction; pulse low, both high gates on.
// - Disable shutdown forces all gates off, nodes floating, both flags released.
// - Undervoltage turns off only affected gates and recovers by itself.
// - Fault flag low while undervoltage or a short-circuit latch blocks a commanded gate, outside shutdown.
// - Undervoltage shutdown also pulls the cause flag low.
// - Short circuit latches its half-bridge off; cause flag stays high.
// - Node of a half-bridge shut by fault is left floating.
// - Overtemperature pulls cause flag low while no commanded gate is blocked, outside shutdown; fault flag and gates stay normal.
// - Disable pulse of 3.1 to 3.6 us clears latched faults, no shutdown.
// - Disable held over 7 us shuts all stages down, gates pulled low.
`timescale 1ns/1ps
`include "hbg_regs.svh"

module hbg_gate_logic #(
  parameter int DEAD_W = 8,
  parameter int CNT_W  = 10
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Controller inputs
  input  wire logic        i_dir,
  input  wire logic        i_pwm,
  input  wire logic        i_deadtime_disable_in,
  // Protection conditions
  input  wire logic [3:0]  i_undervoltage_cond,
  input  wire logic [3:0]  i_short_circuit_cond,
  input  wire logic        i_overtemp_cond,
  // Gate commands
  output logic             o_high_gate_a,
  output logic             o_low_gate_a,
  output logic             o_high_gate_b,
  output logic             o_low_gate_b,
  // Bridge nodes
  output logic             o_bridge_node_a,
  output logic             o_bridge_node_a_oe,
  output logic             o_bridge_node_b,
  output logic             o_bridge_node_b_oe,
  // Open-drain flags
  output logic             o_fault_flag_n_out,
  output logic             o_fault_flag_n_oe,
  output logic             o_cause_flag_n_out,
  output logic             o_cause_flag_n_oe,
  // Interrupt
  output logic             o_irq
);

  if (CNT_W < 2 || `HBG_SHUT_CYC >= (1 << CNT_W)) begin : g_chk
    $error("CNT_W too small for disable timing");
  end

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] MIN_C   = CNT_W'(`HBG_CLR_MIN_CYC);
  localparam logic [CNT_W-1:0] MAX_C   = CNT_W'(`HBG_CLR_MAX_CYC);
  localparam logic [CNT_W-1:0] SHUT_C  = CNT_W'(`HBG_SHUT_CYC);

  // Disable tracker
  hbg_pkg::hbg_dis_e dis_state;
  hbg_pkg::hbg_dis_e next_dis_state;
  logic [CNT_W-1:0]  dis_cnt;
  logic [CNT_W-1:0]  next_dis_cnt;
  logic              clr_pulse;
  logic              enter_shut;

  always_comb begin
    next_dis_state = dis_state;
    next_dis_cnt   = dis_cnt;
    clr_pulse      = 1'b0;
    enter_shut     = 1'b0;
    unique case (dis_state)
      hbg_pkg::DIS_LOW: begin
        if (i_deadtime_disable_in) begin
          next_dis_state = hbg_pkg::DIS_HIGH;
          next_dis_cnt   = CNT_ONE;
        end
      end
      hbg_pkg::DIS_HIGH: begin
        if (i_deadtime_disable_in) begin
          if (dis_cnt == SHUT_C - CNT_ONE) begin
            next_dis_state = hbg_pkg::DIS_SHUT;
            enter_shut     = 1'b1;
          end else begin
            next_dis_cnt = dis_cnt + CNT_ONE;
          end
        end else begin
          clr_pulse      = (dis_cnt >= MIN_C) && (dis_cnt <= MAX_C);
          next_dis_state = hbg_pkg::DIS_LOW;
          next_dis_cnt   = '0;
        end
      end
      hbg_pkg::DIS_SHUT: begin
        if (!i_deadtime_disable_in) begin
          next_dis_state = hbg_pkg::DIS_LOW;
          next_dis_cnt   = '0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dis_state <= hbg_pkg::DIS_LOW;
      dis_cnt   <= '0;
    end else begin
      dis_state <= next_dis_state;
      dis_cnt   <= next_dis_cnt;
    end
  end

  // Protection and flags
  logic [3:0] cmd;
  logic [3:0] allowed;
  logic [3:0] want;
  logic [3:0] gates;
  logic       shut;
  logic       mismatch;
  logic       uv_hit;
  logic [1:0] sc_set;
  logic [1:0] affected;
  logic [1:0] sc_lat;
  logic [1:0] next_sc_lat;
  logic       fault_oe;
  logic       next_fault_oe;
  logic       cause_oe;
  logic       next_cause_oe;
  logic [1:0] node;
  logic [1:0] next_node;
  logic [1:0] node_oe;
  logic [1:0] next_node_oe;
  logic       uv_prev;
  logic       ot_prev;
  logic [`HBG_IRQ_W-1:0] ev;

  always_comb begin
    cmd      = hbg_pkg::hbg_cmd(i_dir, i_pwm);
    shut     = (dis_state == hbg_pkg::DIS_SHUT);
    sc_set   = {|i_short_circuit_cond[3:2], |i_short_circuit_cond[1:0]};
    // undervoltage masks only its own switch
    allowed  = ~i_undervoltage_cond & ~{{2{sc_lat[1]}}, {2{sc_lat[0]}}};
    want     = shut ? 4'h0 : (cmd & allowed);
    mismatch = !shut && (|(cmd & ~allowed));
    uv_hit   = !shut && (|(cmd & i_undervoltage_cond));
    affected = {sc_lat[1] | (|(cmd[3:2] & i_undervoltage_cond[3:2])),
                sc_lat[0] | (|(cmd[1:0] & i_undervoltage_cond[1:0]))};
    // latch until clear, new fault wins
    next_sc_lat   = (sc_lat & ~{2{clr_pulse | enter_shut}}) | sc_set;
    next_fault_oe = mismatch;
    next_cause_oe = uv_hit || (!shut && i_overtemp_cond && !mismatch);
    // floating node when affected or shut
    next_node_oe  = {2{!shut}} & ~affected;
    next_node     = {cmd[`HBG_G_HB], cmd[`HBG_G_HA]};
    ev = '0;
    ev[`HBG_IRQ_FAULT] = mismatch & ~fault_oe;
    ev[`HBG_IRQ_SC]    = |(sc_set & ~sc_lat);
    ev[`HBG_IRQ_UV]    = uv_hit & ~uv_prev;
    ev[`HBG_IRQ_OT]    = i_overtemp_cond & ~ot_prev;
    ev[`HBG_IRQ_CLR]   = clr_pulse;
    ev[`HBG_IRQ_SHUT]  = enter_shut;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sc_lat   <= '0;
      fault_oe <= 1'b0;
      cause_oe <= 1'b0;
      node     <= '0;
      node_oe  <= '0;
      uv_prev  <= 1'b0;
      ot_prev  <= 1'b0;
    end else begin
      sc_lat   <= next_sc_lat;
      fault_oe <= next_fault_oe;
      cause_oe <= next_cause_oe;
      node     <= next_node;
      node_oe  <= next_node_oe;
      uv_prev  <= uv_hit;
      ot_prev  <= i_overtemp_cond;
    end
  end

  // Half-bridge drivers
  logic [DEAD_W-1:0] dead;
  hbg_hb_if #(.DEAD_W(DEAD_W)) hb_a ();
  hbg_hb_if #(.DEAD_W(DEAD_W)) hb_b ();

  assign hb_a.want_hi = want[`HBG_G_HA];
  assign hb_a.want_lo = want[`HBG_G_LA];
  assign hb_a.dead    = dead;
  assign hb_b.want_hi = want[`HBG_G_HB];
  assign hb_b.want_lo = want[`HBG_G_LB];
  assign hb_b.dead    = dead;

  hbg_half_bridge #(.DEAD_W(DEAD_W)) u_hb_a (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .hb       (hb_a.drv)
  );

  hbg_half_bridge #(.DEAD_W(DEAD_W)) u_hb_b (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .hb       (hb_b.drv)
  );

  assign gates = {hb_b.gate_lo, hb_b.gate_hi, hb_a.gate_lo, hb_a.gate_hi};

  // APB registers
  logic [`HBG_IRQ_W-1:0] irq_stat;
  logic [`HBG_IRQ_W-1:0] next_irq_stat;
  logic [`HBG_IRQ_W-1:0] irq_en;
  logic [`HBG_IRQ_W-1:0] next_irq_en;
  logic [`HBG_IRQ_W-1:0] irq_clr;
  logic [DEAD_W-1:0]     next_dead;
  logic [31:0]           prdata;
  logic [31:0]           next_prdata;
  logic                  wr;

  function automatic logic addr_known(input logic [7:0] a);
    return a == `HBG_OFF_DEAD || a == `HBG_OFF_STATE ||
           a == `HBG_OFF_IRQ_STAT || a == `HBG_OFF_IRQ_EN ||
           a == `HBG_OFF_IRQ_CLR;
  endfunction

  always_comb begin
    wr          = i_psel && i_penable && i_pwrite && addr_known(i_paddr);
    next_dead   = dead;
    next_irq_en = irq_en;
    irq_clr     = '0;
    next_prdata = prdata;
    if (wr && i_paddr == `HBG_OFF_DEAD) begin
      next_dead = i_pwdata[DEAD_W-1:0];
    end
    if (wr && i_paddr == `HBG_OFF_IRQ_EN) begin
      next_irq_en = i_pwdata[`HBG_IRQ_W-1:0];
    end
    if (wr && i_paddr == `HBG_OFF_IRQ_CLR) begin
      irq_clr = i_pwdata[`HBG_IRQ_W-1:0];
    end
    // Set wins over clear
    next_irq_stat = (irq_stat & ~irq_clr) | ev;
    if (i_psel && !i_penable) begin
      next_prdata = '0;
      case (i_paddr)
        `HBG_OFF_DEAD:     next_prdata[DEAD_W-1:0] = dead;
        `HBG_OFF_STATE: begin
          next_prdata[`HBG_ST_GATE_LSB +: 4] = gates;
          next_prdata[`HBG_ST_SC_LSB +: 2]   = sc_lat;
          next_prdata[`HBG_ST_SHUT]          = shut;
          next_prdata[`HBG_ST_FAULT]         = fault_oe;
          next_prdata[`HBG_ST_CAUSE]         = cause_oe;
        end
        `HBG_OFF_IRQ_STAT: next_prdata[`HBG_IRQ_W-1:0] = irq_stat;
        `HBG_OFF_IRQ_EN:   next_prdata[`HBG_IRQ_W-1:0] = irq_en;
        default:           next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dead     <= DEAD_W'(`HBG_DEAD_RST);
      irq_en   <= `HBG_IRQ_W'(`HBG_IRQ_EN_RST);
      irq_stat <= '0;
      prdata   <= '0;
    end else begin
      dead     <= next_dead;
      irq_en   <= next_irq_en;
      irq_stat <= next_irq_stat;
      prdata   <= next_prdata;
    end
  end

  // Outputs
  assign o_prdata           = prdata;
  assign o_pready           = 1'b1;
  assign o_pslverr          = i_psel && i_penable && !addr_known(i_paddr);
  assign o_high_gate_a      = gates[`HBG_G_HA];
  assign o_low_gate_a       = gates[`HBG_G_LA];
  assign o_high_gate_b      = gates[`HBG_G_HB];
  assign o_low_gate_b       = gates[`HBG_G_LB];
  assign o_bridge_node_a    = node[0];
  assign o_bridge_node_a_oe = node_oe[0];
  assign o_bridge_node_b    = node[1];
  assign o_bridge_node_b_oe = node_oe[1];
  assign o_fault_flag_n_out = 1'b0;
  assign o_fault_flag_n_oe  = fault_oe;
  assign o_cause_flag_n_out = 1'b0;
  assign o_cause_flag_n_oe  = cause_oe;
  assign o_irq              = |(irq_stat & irq_en);

  // Checks
  a_cmd_map: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_pwm && !i_dir) |-> cmd == `HBG_CMD_FWD)
    else $error("pattern map wrong for forward");

  a_shut_quiet: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (shut && $past(shut)) |-> (gates == 4'h0 && node_oe == 2'b00 &&
                              !fault_oe && !cause_oe))
    else $error("outputs active during shutdown");

  a_uv_recover: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_undervoltage_cond == 4'h0 && sc_lat == 2'b00 && !shut)
    |-> want == cmd)
    else $error("no self recovery after undervoltage");

  a_fault_flag: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    mismatch |=> fault_oe)
    else $error("fault flag not pulled on mismatch");

  a_uv_cause: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    uv_hit |=> (fault_oe && cause_oe))
    else $error("undervoltage not reported");

  a_sc_latched: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (sc_lat[0] && $past(sc_lat[0])) |-> !(o_high_gate_a || o_low_gate_a))
    else $error("latched half-bridge a still driven");

  a_node_float: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    affected[1] |=> !node_oe[1])
    else $error("affected node b still driven");

  a_ot_warn: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_overtemp_cond && !mismatch && !shut) |=> (cause_oe && !fault_oe))
    else $error("overtemperature warning wrong");

  a_diag_clear: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (clr_pulse && sc_set == 2'b00) |=> (sc_lat == 2'b00 && !shut))
    else $error("clearing pulse did not clear latch");

  a_long_dis: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (dis_state == hbg_pkg::DIS_HIGH && dis_cnt == SHUT_C - CNT_ONE &&
     i_deadtime_disable_in) |=> shut ##1 (gates == 4'h0))
    else $error("long disable did not shut down");

endmodule // hbg_gate_logic

// ### hdl/hbg_half_bridge.sv
// Purpose: gate pair of one half-bridge with dead interval
// Assumes: want_hi and want_lo never both high
// Notes:   turn-off is immediate, turn-on waits out the dead count
`timescale 1ns/1ps

module hbg_half_bridge #(
  parameter int DEAD_W = 8
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Commands and gates
  hbg_hb_if.drv     hb
);

  if (DEAD_W < 1 || DEAD_W > 16) begin : g_chk
    $error("DEAD_W out of range");
  end

  logic              gate_hi;
  logic              gate_lo;
  logic [DEAD_W-1:0] cnt;
  logic              next_gate_hi;
  logic              next_gate_lo;
  logic [DEAD_W-1:0] next_cnt;

  always_comb begin
    next_cnt     = (cnt != '0) ? cnt - DEAD_W'(1) : cnt;
    next_gate_hi = gate_hi & hb.want_hi;
    next_gate_lo = gate_lo & hb.want_lo;
    if ((gate_hi & ~hb.want_hi) | (gate_lo & ~hb.want_lo)) begin
      next_cnt = hb.dead;
    end
    if (hb.want_hi && !gate_hi && !gate_lo && cnt == '0) begin
      next_gate_hi = 1'b1;
    end
    if (hb.want_lo && !gate_lo && !gate_hi && cnt == '0) begin
      next_gate_lo = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
      cnt     <= '0;
    end else begin
      gate_hi <= next_gate_hi;
      gate_lo <= next_gate_lo;
      cnt     <= next_cnt;
    end
  end

  assign hb.gate_hi = gate_hi;
  assign hb.gate_lo = gate_lo;

  a_no_overlap: assert property (
    @(posedge i_clk) disable iff (!i_resetn) !(gate_hi && gate_lo))
    else $error("both gates of a half-bridge on");

  a_gap_after_lo: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ($fell(gate_lo) || $fell(gate_hi)) |-> !(gate_hi || gate_lo))
    else $error("no dead interval after turn-off");

endmodule // hbg_half_bridge

// ### hdl/hbg_hb_if.sv
// Purpose: signals between the control core and one half-bridge driver
// Assumes: one clock domain
// Notes:   ctl side commands, drv side drives the gates
`timescale 1ns/1ps

interface hbg_hb_if #(
  parameter int DEAD_W = 8
);
  logic              want_hi;
  logic              want_lo;
  logic [DEAD_W-1:0] dead;
  logic              gate_hi;
  logic              gate_lo;

  modport ctl (output want_hi, output want_lo, output dead,
               input gate_hi, input gate_lo);
  modport drv (input want_hi, input want_lo, input dead,
               output gate_hi, output gate_lo);
endinterface

// ### hdl/hbg_pkg.sv
// Purpose: types and pattern function of the gate logic
// Assumes: hbg_regs.svh holds all numbers
// Notes:   nothing imported by users
`include "hbg_regs.svh"

package hbg_pkg;

  typedef enum logic [1:0] {
    DIS_LOW,
    DIS_HIGH,
    DIS_SHUT
  } hbg_dis_e;

  // Gate pattern commanded by direction and pulse inputs
  function automatic logic [3:0] hbg_cmd(input logic dir, input logic pwm);
    logic [3:0] pat;
    pat = `HBG_CMD_BRAKE;
    if (pwm) begin
      pat = dir ? `HBG_CMD_REV : `HBG_CMD_FWD;
    end
    return pat;
  endfunction

endpackage

// ### hdl/hbg_regs.svh
// Purpose: register map, field positions and timing counts of the gate logic
// Assumes: 100 MHz clock; APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef HBG_REGS_SVH
`define HBG_REGS_SVH

// Clock and disable-pulse timing
`define HBG_CLK_NS         10
`define HBG_CLR_MIN_NS     3100
`define HBG_CLR_MAX_NS     3600
`define HBG_SHUT_NS        7000
`define HBG_CLR_MIN_CYC    ((`HBG_CLR_MIN_NS + `HBG_CLK_NS - 1) / `HBG_CLK_NS)
`define HBG_CLR_MAX_CYC    (`HBG_CLR_MAX_NS / `HBG_CLK_NS)
`define HBG_SHUT_CYC       ((`HBG_SHUT_NS + `HBG_CLK_NS - 1) / `HBG_CLK_NS)

// Register offsets
`define HBG_OFF_DEAD       8'h00
`define HBG_OFF_STATE      8'h04
`define HBG_OFF_IRQ_STAT   8'h08
`define HBG_OFF_IRQ_EN     8'h0C
`define HBG_OFF_IRQ_CLR    8'h10

// Reset values
`define HBG_DEAD_RST       32'h0000_000A
`define HBG_IRQ_EN_RST     32'h0000_0000

// State register fields
`define HBG_ST_GATE_LSB    0
`define HBG_ST_SC_LSB      4
`define HBG_ST_SHUT        6
`define HBG_ST_FAULT       7
`define HBG_ST_CAUSE       8

// Interrupt bits
`define HBG_IRQ_FAULT      0
`define HBG_IRQ_SC         1
`define HBG_IRQ_UV         2
`define HBG_IRQ_OT         3
`define HBG_IRQ_CLR        4
`define HBG_IRQ_SHUT       5
`define HBG_IRQ_W          6

// Gate vector positions
`define HBG_G_HA           0
`define HBG_G_LA           1
`define HBG_G_HB           2
`define HBG_G_LB           3

// Commanded gate patterns
`define HBG_CMD_FWD        4'h9
`define HBG_CMD_REV        4'h6
`define HBG_CMD_BRAKE      4'h5

`endif

// ### verif/hbg_ctrl_model.sv
// Purpose: controller model on direction, pulse and disable pins
// Assumes: both flags are open drain with pull-ups
// Notes:   every change follows a rising edge
`timescale 1ns/1ps

module hbg_ctrl_model (
  // Clock
  input  wire logic i_clk,
  // Flag pins
  input  wire logic i_fault_out,
  input  wire logic i_fault_oe,
  input  wire logic i_cause_out,
  input  wire logic i_cause_oe,
  // Drive and resolved flags
  output logic      o_dir,
  output logic      o_pwm,
  output logic      o_dis,
  output logic      o_fault_n,
  output logic      o_cause_n
);
  initial begin
    o_dir = 1'b0;
    o_pwm = 1'b0;
    o_dis = 1'b0;
  end
  // Pull-ups on released flags
  assign o_fault_n = i_fault_oe ? i_fault_out : 1'b1;
  assign o_cause_n = i_cause_oe ? i_cause_out : 1'b1;
  task automatic drive(input logic d, input logic p);
    @(posedge i_clk);
    o_dir <= d;
    o_pwm <= p;
  endtask
  task automatic decay(input logic d);
    drive(d, 1'b1);
  endtask
  task automatic pulse(input int n);
    @(posedge i_clk);
    o_dis <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_dis <= 1'b0;
  endtask
  task automatic hold(input int n);
    @(posedge i_clk);
    o_dis <= 1'b1;
    repeat (n) @(posedge i_clk);
  endtask
  task automatic release_dis();
    @(posedge i_clk);
    o_dis <= 1'b0;
  endtask
endmodule // hbg_ctrl_model

// ### verif/hbg_gate_logic_test.sv
// Purpose: self-checking bench of the gate command logic
// Assumes: default parameters, zero-wait APB slave
// Notes:   reset and register reads first, then row table, then hand-written cases
`timescale 1ns/1ps
`include "hbg_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h, expected %h", $time, g, e); end end

module hbg_gate_logic_test;
  typedef struct packed {
    logic       dir, pwm;
    logic [3:0] uv, sc;
    logic       ot;
    logic [3:0] gt;
    logic       fn, cn;
    logic [1:0] oe, nd;
  } hbg_row_s;
  logic        i_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0;
  logic        i_pwrite = 0, i_overtemp_cond = 0;
  logic [7:0]  i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic [3:0]  i_undervoltage_cond = 0, i_short_circuit_cond = 0, gates;
  logic        o_pready, o_pslverr, i_dir, i_pwm, i_deadtime_disable_in;
  logic        o_high_gate_a, o_low_gate_a, o_high_gate_b, o_low_gate_b;
  logic        o_bridge_node_a, o_bridge_node_a_oe, o_irq, er;
  logic        o_bridge_node_b, o_bridge_node_b_oe, fault_n, cause_n;
  logic        o_fault_flag_n_out, o_fault_flag_n_oe;
  logic        o_cause_flag_n_out, o_cause_flag_n_oe;
  logic [1:0]  oe, nd;
  int          err_total = 0, cmp_count = 0, cyc = 0, n;
  hbg_row_s    rows [12] = '{
    '{0,1,0,0,0,4'h9,1,1,2'b11,2'b01}, '{0,0,0,0,0,4'h5,1,1,2'b11,2'b11},
    '{1,1,0,0,0,4'h6,1,1,2'b11,2'b10}, '{1,0,0,0,0,4'h5,1,1,2'b11,2'b11},
    '{0,1,0,0,1,4'h9,1,0,2'b11,2'b01}, '{1,0,0,0,1,4'h5,1,0,2'b11,2'b11},
    '{0,1,1,0,0,4'h8,0,0,2'b10,2'b00}, '{1,0,4,0,0,4'h1,0,0,2'b01,2'b01},
    '{1,1,1,0,0,4'h6,1,1,2'b11,2'b10}, '{0,1,0,1,0,4'h8,0,1,2'b10,2'b00},
    '{1,0,0,8,0,4'h1,0,1,2'b01,2'b01}, '{1,1,0,4,0,4'h2,0,1,2'b01,2'b00}};
  int          lens [4] = '{309, 310, 360, 361};

  assign gates = {o_low_gate_b, o_high_gate_b, o_low_gate_a, o_high_gate_a};
  assign oe    = {o_bridge_node_b_oe, o_bridge_node_a_oe};
  assign nd    = {o_bridge_node_b, o_bridge_node_a} & oe;
  always #5 i_clk = ~i_clk;

  hbg_gate_logic i_hbg_gate_logic (.i_clk, .i_resetn, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_dir, .i_pwm, .i_deadtime_disable_in, .i_undervoltage_cond,
    .i_short_circuit_cond, .i_overtemp_cond, .o_high_gate_a, .o_low_gate_a,
    .o_high_gate_b, .o_low_gate_b, .o_bridge_node_a, .o_bridge_node_a_oe,
    .o_bridge_node_b, .o_bridge_node_b_oe, .o_fault_flag_n_out,
    .o_fault_flag_n_oe, .o_cause_flag_n_out, .o_cause_flag_n_oe, .o_irq);
  hbg_ctrl_model i_hbg_ctrl_model (.i_clk, .i_fault_out(o_fault_flag_n_out),
    .i_fault_oe(o_fault_flag_n_oe), .i_cause_out(o_cause_flag_n_out),
    .i_cause_oe(o_cause_flag_n_oe), .o_dir(i_dir), .o_pwm(i_pwm),
    .o_dis(i_deadtime_disable_in), .o_fault_n(fault_n),
    .o_cause_n(cause_n));

  task automatic test_done();
    $display("Compares %0d, errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) begin
      @(posedge i_clk);
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(negedge i_clk);
  endtask

  task automatic conds(input logic [3:0] u, input logic [3:0] s,
                       input logic t);
    @(posedge i_clk);
    i_undervoltage_cond <= u;
    i_short_circuit_cond <= s;
    i_overtemp_cond <= t;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end

  always @(negedge i_clk) begin
    if (i_resetn) `CHK(gates & (gates >> 1) & 4'h5, 4'h0)
  end

  initial begin
    repeat (10) @(negedge i_clk);
    `CHK({gates, fault_n, cause_n, oe}, 8'h0C)
    repeat (11) @(posedge i_clk);
    i_resetn <= 1'b1;
    apb(0, `HBG_OFF_DEAD, 0);
    `CHK(rd, `HBG_DEAD_RST)
    apb(0, `HBG_OFF_IRQ_EN, 0);
    `CHK(rd, `HBG_IRQ_EN_RST)
    apb(0, 8'h20, 0);
    `CHK({er, rd}, 33'h1_0000_0000)
    foreach (rows[i]) begin
      i_hbg_ctrl_model.drive(rows[i].dir, rows[i].pwm);
      conds(rows[i].uv, rows[i].sc, rows[i].ot);
      repeat (30) @(negedge i_clk);
      `CHK(gates, rows[i].gt)
      `CHK({fault_n, cause_n}, {rows[i].fn, rows[i].cn})
      `CHK({oe, nd}, {rows[i].oe, rows[i].nd})
      conds(0, 0, 0);
      i_hbg_ctrl_model.pulse(340);
      repeat (20) @(posedge i_clk);
    end
    apb(0, `HBG_OFF_IRQ_STAT, 0);
    `CHK(rd[`HBG_IRQ_CLR], 1'b1)
    i_hbg_ctrl_model.drive(0, 1);
    foreach (lens[i]) begin
      conds(0, 1, 0);
      conds(0, 0, 0);
      repeat (20) @(negedge i_clk);
      `CHK(gates, 4'h8)
      i_hbg_ctrl_model.pulse(lens[i]);
      repeat (20) @(negedge i_clk);
      `CHK(gates, (i == 1 || i == 2) ? 4'h9 : 4'h8)
      i_hbg_ctrl_model.pulse(340);
      repeat (20) @(posedge i_clk);
    end
    apb(1, `HBG_OFF_DEAD, 3);
    apb(0, `HBG_OFF_DEAD, 0);
    `CHK(rd, 32'h0000_0003)
    i_hbg_ctrl_model.decay(1);
    n = 0;
    while (gates !== 4'h0 && n < 10) begin
      @(negedge i_clk);
      n++;
    end
    n = 0;
    while (gates !== 4'h6 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(n, 4)
    i_hbg_ctrl_model.decay(0);
    apb(1, `HBG_OFF_IRQ_EN, 1);
    apb(1, `HBG_OFF_IRQ_CLR, 32'h0000_003F);
    `CHK(o_irq, 1'b0)
    conds(1, 0, 0);
    repeat (20) @(negedge i_clk);
    `CHK(o_irq, 1'b1)
    conds(0, 0, 0);
    repeat (20) @(negedge i_clk);
    `CHK(o_irq, 1'b1)
    apb(1, `HBG_OFF_IRQ_EN, 0);
    `CHK(o_irq, 1'b0)
    apb(1, `HBG_OFF_IRQ_EN, 1);
    `CHK(o_irq, 1'b1)
    apb(1, `HBG_OFF_IRQ_CLR, 1);
    `CHK(o_irq, 1'b0)
    conds(1, 0, 0);
    repeat (20) @(posedge i_clk);
    i_hbg_ctrl_model.hold(700);
    @(negedge i_clk);
    `CHK(gates, 4'h8)
    @(negedge i_clk);
    `CHK({gates, fault_n, cause_n, oe}, 8'h0C)
    i_hbg_ctrl_model.release_dis();
    repeat (20) @(negedge i_clk);
    `CHK(gates, 4'h8)
    apb(0, `HBG_OFF_IRQ_STAT, 0);
    `CHK(rd, 32'h0000_0025)
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (3) @(negedge i_clk);
    `CHK({gates, fault_n, cause_n, oe}, 8'h0C)
    @(posedge i_clk);
    i_resetn <= 1'b1;
    apb(0, `HBG_OFF_DEAD, 0);
    `CHK(rd, `HBG_DEAD_RST)
    test_done();
  end
endmodule // hbg_gate_logic_test
